/* eag_level_bank.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Per-level index registers and base page flags
// ----------------------------------------------------------------
module eag_level_bank
	import eag_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic xr_wr,
	input wire logic [EAG_LVL_W-1:0] xr_wr_level,
	input wire logic [EAG_WORD_W-1:0] xr_wdata,
	input wire logic bp_wr,
	input wire logic [EAG_LVL_W-1:0] bp_wr_level,
	input wire logic bp_wdata,
	input wire logic [EAG_LVL_W-1:0] rd_level,
	output logic [EAG_WORD_W-1:0] xreg,
	output logic bflag
);
	// Storage, one entry per program level
	logic [EAG_WORD_W-1:0] xreg_q [EAG_LEVELS];
	logic bflag_q [EAG_LEVELS];

	// ----------------------------------------------------------------
	// Storage per level
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < EAG_LEVELS; g++) begin : g_level
			// Each level keeps its own index word and page flag
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					xreg_q[g] <= EAG_WORD_RST;
					bflag_q[g] <= EAG_BFLAG_RST;
				end else begin
					if (xr_wr && xr_wr_level == EAG_LVL_W'(g)) begin
						xreg_q[g] <= xr_wdata;
					end
					if (bp_wr && bp_wr_level == EAG_LVL_W'(g)) begin
						bflag_q[g] <= bp_wdata;
					end
				end
			end
		end
	endgenerate

	// Reads select the level being served
	assign xreg = xreg_q[rd_level];
	assign bflag = bflag_q[rd_level];
endmodule : eag_level_bank

/* eag_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Core memory model answering indirect word reads
// ----------------------------------------------------------------
module eag_mem_model
	import eag_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic mem_rd_q,
	input wire logic [EAG_WORD_W-1:0] mem_addr_q,
	input wire logic [3:0] lat,
	output logic mem_ack,
	output logic [EAG_WORD_W-1:0] mem_rdata
);
	// Wait cycles spent on the current read
	logic [3:0] wait_q;
	// Answer after lat cycles; data toggles outside the ack pulse
	always @(negedge clk or negedge resetn) begin
		if (!resetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0000;
			wait_q <= 4'h0;
		end else if (mem_ack || !mem_rd_q) begin
			// Released: stale data must not look valid
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_q <= 4'h0;
		end else if (wait_q >= lat) begin
			// Word content is a byte swap of its address plus a bias
			mem_ack <= 1'b1;
			mem_rdata <= {mem_addr_q[7:0], mem_addr_q[15:8]} + 16'h0101;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule : eag_mem_model

/* eag_page_former.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Local page and base page direct address forming
// ----------------------------------------------------------------
module eag_page_former
	import eag_pkg::*;
(
	input wire logic [EAG_WORD_W-1:0] loc,
	input wire logic [EAG_DISP_W-1:0] disp,
	input wire logic bflag,
	output logic [EAG_WORD_W-1:0] local_addr,
	output logic [EAG_WORD_W-1:0] base_addr
);
	// Expanding base page number: top three location bits plus one
	logic [3:0] exp_page;

	// Local page: upper seven location bits, then the displacement
	assign local_addr = {loc[15:9], disp};
	assign exp_page = {1'b0, loc[15:13]} + 4'h1;
	// Fixed page one or the expanding page, below leading zeros
	assign base_addr = bflag ? {EAG_FIXED_PAGE, disp} : {3'h0, exp_page, disp};
endmodule : eag_page_former

/* eag_pkg.sv */
// ----------------------------------------------------------------
// Shared constants for the effective address generator
// ----------------------------------------------------------------
package eag_pkg;
	// Word and field widths
	localparam int EAG_WORD_W = 16;
	localparam int EAG_DISP_W = 9;
	localparam int EAG_LVL_W = 2;
	localparam int EAG_LEVELS = 4;
	// Tag bit positions (instruction bits 4, 5, 6 counted from the msb)
	localparam int EAG_TAG_IND_POS = 11;
	localparam int EAG_TAG_IDX_POS = 10;
	localparam int EAG_TAG_PAGE_POS = 9;
	// Immediate byte and offset nibble widths
	localparam int EAG_BYTE_W = 8;
	localparam int EAG_NIB_W = 4;
	// Fixed base page number (page one)
	localparam logic [6:0] EAG_FIXED_PAGE = 7'h01;
	// Reset values
	localparam logic [15:0] EAG_WORD_RST = 16'h0000;
	localparam logic EAG_BFLAG_RST = 1'b0;
	// Kinds of address request
	localparam logic [1:0] EAG_KIND_MEMREF = 2'h0;
	localparam logic [1:0] EAG_KIND_IDX_DIR = 2'h1;
	localparam logic [1:0] EAG_KIND_IDX_IND = 2'h2;
	localparam logic [1:0] EAG_KIND_IMM = 2'h3;
	// Immediate byte operations
	localparam logic [1:0] EAG_IMM_LOAD = 2'h0;
	localparam logic [1:0] EAG_IMM_ADD = 2'h1;
	localparam logic [1:0] EAG_IMM_SUB = 2'h2;
	// Timing: one microsecond of extra time at 125 MHz
	localparam int EAG_CLK_MHZ = 125;
	localparam int EAG_EXTRA_STEP_US = 1;
	localparam int EAG_US_CYCLES = EAG_EXTRA_STEP_US * EAG_CLK_MHZ;
	localparam int EAG_CNT_W = 10;
	// Sequencer states
	typedef enum logic [2:0] {
		EAG_IDLE,
		EAG_READ,
		EAG_HOLD
	} eag_state_type;
endpackage : eag_pkg

/* eag_top.sv */
`timescale 1ns/1ps
module eag_top
	import eag_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [1:0] op_kind,
	input wire logic [1:0] imm_op,
	input wire logic [EAG_WORD_W-1:0] instr,
	input wire logic [EAG_WORD_W-1:0] loc,
	input wire logic [EAG_LVL_W-1:0] level,
	input wire logic [EAG_WORD_W-1:0] acc_in,
	input wire logic [EAG_WORD_W-1:0] mem_rdata,
	input wire logic mem_ack,
	input wire logic xr_wr,
	input wire logic [EAG_LVL_W-1:0] xr_wr_level,
	input wire logic [EAG_WORD_W-1:0] xr_wdata,
	input wire logic bp_wr,
	input wire logic [EAG_LVL_W-1:0] bp_wr_level,
	input wire logic bp_wdata,
	output logic busy_q,
	output logic mem_rd_q,
	output logic [EAG_WORD_W-1:0] mem_addr_q,
	output logic [EAG_WORD_W-1:0] ea_q,
	output logic ea_valid_q,
	output logic [EAG_WORD_W-1:0] acc_out_q,
	output logic acc_valid_q,
	output logic bflag_q,
	output logic [1:0] extra_us_q
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	eag_state_type state_q; // Sequencer state
	logic [EAG_LVL_W-1:0] level_q; // Level latched for the request
	logic [1:0] reads_q; // Indirect reads still to do
	logic [EAG_WORD_W-1:0] addend_q; // Added after the last read
	logic [EAG_CNT_W-1:0] cnt_q; // Cycles since request
	logic [EAG_CNT_W-1:0] need_q; // Cycles of extra time required
	logic [EAG_WORD_W-1:0] xreg; // Index word of the active level
	logic bflag; // Page flag of the active level
	logic [EAG_WORD_W-1:0] local_addr; // Local page direct address
	logic [EAG_WORD_W-1:0] base_addr; // Base page direct address
	logic [EAG_LVL_W-1:0] rd_level; // Level that the bank serves
	logic tag_ind; // Indirect tag
	logic tag_idx; // Index tag
	logic tag_page; // Page tag
	logic [EAG_DISP_W-1:0] disp; // Page displacement
	logic [EAG_WORD_W-1:0] nib_ext; // Offset nibble, zero extended
	logic [EAG_WORD_W-1:0] byte_ext; // Immediate byte, zero extended
	logic take; // Request accepted this cycle
	logic is_mem; // Memory reference request
	logic [1:0] mem_reads; // Indirect reads for a memory reference
	logic [1:0] first_reads; // Indirect reads for this request
	logic [EAG_WORD_W-1:0] first_ptr; // Address after page selection
	logic [EAG_WORD_W-1:0] first_add; // Value added after the reads
	logic [1:0] extra_us; // Extra microseconds of the mode
	logic [EAG_CNT_W-1:0] extra_cyc; // Extra time in cycles
	logic [EAG_WORD_W-1:0] imm_result; // Accumulator after immediate op
	logic hold_done; // Extra time elapsed in hold
	logic [EAG_WORD_W-1:0] final_sum; // Final effective address

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	// Tags from bits 4-6
	assign tag_ind = instr[EAG_TAG_IND_POS];
	assign tag_idx = instr[EAG_TAG_IDX_POS];
	assign tag_page = instr[EAG_TAG_PAGE_POS];
	assign disp = instr[EAG_DISP_W-1:0];
	assign nib_ext = {12'h000, instr[EAG_NIB_W-1:0]};
	assign byte_ext = {8'h00, instr[EAG_BYTE_W-1:0]};
	assign take = start && state_q == EAG_IDLE;
	assign is_mem = op_kind == EAG_KIND_MEMREF;
	assign rd_level = take ? level : level_q;

	// ----------------------------------------------------------------
	// Per-level storage and page forming
	// ----------------------------------------------------------------
	// Flag and index chosen by level
	eag_level_bank u_bank (
		.clk(clk),
		.resetn(resetn),
		.xr_wr(xr_wr),
		.xr_wr_level(xr_wr_level),
		.xr_wdata(xr_wdata),
		.bp_wr(bp_wr),
		.bp_wr_level(bp_wr_level),
		.bp_wdata(bp_wdata),
		.rd_level(rd_level),
		.xreg(xreg),
		.bflag(bflag)
	);

	eag_page_former u_page (
		.loc(loc),
		.disp(disp),
		.bflag(bflag),
		.local_addr(local_addr),
		.base_addr(base_addr)
	);

	// ----------------------------------------------------------------
	// Request planning
	// ----------------------------------------------------------------
	// Base page adds one read
	assign mem_reads = {1'b0, ~tag_page} + {1'b0, tag_ind};
	// Index forms: direct or one read
	assign first_reads = is_mem ? mem_reads : ((op_kind == EAG_KIND_IDX_IND) ? 2'h1 : 2'h0);
	assign first_ptr = is_mem ? (tag_page ? local_addr : base_addr) : xreg;
	assign first_add = is_mem ? (tag_idx ? xreg : EAG_WORD_RST) : nib_ext;
	assign extra_us = is_mem ? (mem_reads + {1'b0, tag_idx}) : 2'h0;
	assign extra_cyc = EAG_CNT_W'(extra_us) * EAG_CNT_W'(EAG_US_CYCLES);
	assign imm_result = (imm_op == EAG_IMM_ADD) ? acc_in + byte_ext :
		(imm_op == EAG_IMM_SUB) ? acc_in - byte_ext : byte_ext;
	assign hold_done = cnt_q >= need_q;
	assign final_sum = mem_addr_q + addend_q;

	// ----------------------------------------------------------------
	// Cycle counter for extra time
	// ----------------------------------------------------------------
	// Cleared on a request, saturates at its top
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else if (take) begin
			cnt_q <= '0;
		end else if (cnt_q != '1) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Page select, indirect reads, then indexing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= EAG_IDLE;
			level_q <= '0;
			reads_q <= 2'h0;
			addend_q <= EAG_WORD_RST;
			need_q <= '0;
			mem_rd_q <= 1'b0;
			mem_addr_q <= EAG_WORD_RST;
			ea_q <= EAG_WORD_RST;
			ea_valid_q <= 1'b0;
			acc_out_q <= EAG_WORD_RST;
			acc_valid_q <= 1'b0;
			busy_q <= 1'b0;
			bflag_q <= EAG_BFLAG_RST;
			extra_us_q <= 2'h0;
		end else begin
			ea_valid_q <= 1'b0;
			acc_valid_q <= 1'b0;
			unique case (state_q)
				// Wait for a request
				EAG_IDLE: begin
					if (take) begin
						level_q <= level;
						bflag_q <= bflag;
						if (op_kind == EAG_KIND_IMM) begin
							acc_out_q <= imm_result;
							acc_valid_q <= 1'b1;
						end else begin
							busy_q <= 1'b1;
							reads_q <= first_reads;
							addend_q <= first_add;
							need_q <= extra_cyc;
							extra_us_q <= extra_us;
							mem_addr_q <= first_ptr;
							mem_rd_q <= first_reads != 2'h0;
							state_q <= (first_reads != 2'h0) ? EAG_READ : EAG_HOLD;
						end
					end
				end
				EAG_READ: begin
					if (mem_ack) begin
						mem_addr_q <= mem_rdata;
						reads_q <= reads_q - 2'h1;
						if (reads_q == 2'h1) begin
							mem_rd_q <= 1'b0;
							state_q <= EAG_HOLD;
						end
					end
				end
				// Present after all steps and time
				EAG_HOLD: begin
					if (hold_done) begin
						ea_q <= final_sum;
						ea_valid_q <= 1'b1;
						busy_q <= 1'b0;
						state_q <= EAG_IDLE;
					end
				end
				default: begin
					state_q <= EAG_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [1:0] rd_seen_q; // Reads completed for the request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_seen_q <= 2'h0;
		end else if (take) begin
			rd_seen_q <= 2'h0;
		end else if (mem_rd_q && mem_ack) begin
			rd_seen_q <= rd_seen_q + 2'h1;
		end
	end

	chk_local_indirect: assert property (@(posedge clk) disable iff (!resetn)
		take && is_mem && tag_page && tag_ind |=> mem_rd_q && mem_addr_q == $past(local_addr))
		else $error("local indirect pointer address wrong");

	chk_fixed_base: assert property (@(posedge clk) disable iff (!resetn)
		take && is_mem && !tag_page && bflag |=> mem_rd_q && mem_addr_q[15:9] == EAG_FIXED_PAGE)
		else $error("fixed base page not page one");

	chk_expand_base: assert property (@(posedge clk) disable iff (!resetn)
		take && is_mem && !tag_page && !bflag |=> mem_addr_q == $past(base_addr)
		&& mem_addr_q[15:13] == 3'h0)
		else $error("expanding base page address wrong");

	chk_direct_mode: assert property (@(posedge clk) disable iff (!resetn)
		take && is_mem && instr[11:9] == 3'b001 |=> !mem_rd_q ##1 ea_valid_q
		&& ea_q == $past(local_addr, 2))
		else $error("local direct mode wrong or late");

	logic two_rd_q; // Two pointer reads expected for the request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			two_rd_q <= 1'b0;
		end else if (take) begin
			two_rd_q <= is_mem && !tag_page && tag_ind;
		end
	end

	chk_two_reads: assert property (@(posedge clk) disable iff (!resetn)
		ea_valid_q && two_rd_q |-> rd_seen_q == 2'h2)
		else $error("base page double indirect read count wrong");

	chk_base_pointer: assert property (@(posedge clk) disable iff (!resetn)
		take && is_mem && !tag_page |=> mem_rd_q && mem_addr_q == $past(base_addr))
		else $error("base page word not read as pointer");

	chk_idx_indirect: assert property (@(posedge clk) disable iff (!resetn)
		take && op_kind == EAG_KIND_IDX_IND |=> mem_rd_q && mem_addr_q == $past(xreg)
		&& addend_q == $past(nib_ext))
		else $error("index indirect pointer wrong");

	chk_idx_direct: assert property (@(posedge clk) disable iff (!resetn)
		take && op_kind == EAG_KIND_IDX_DIR |-> ##2 ea_valid_q
		&& ea_q == $past(xreg, 2) + $past(nib_ext, 2))
		else $error("index direct address wrong");

	chk_extra_time: assert property (@(posedge clk) disable iff (!resetn)
		ea_valid_q |-> $past(cnt_q) >= EAG_CNT_W'(extra_us_q) * EAG_CNT_W'(EAG_US_CYCLES))
		else $error("address presented before extra time");

	chk_imm_load: assert property (@(posedge clk) disable iff (!resetn)
		take && op_kind == EAG_KIND_IMM && imm_op == EAG_IMM_LOAD |=> acc_valid_q
		&& acc_out_q == {8'h00, $past(instr[7:0])})
		else $error("immediate load result wrong");

	chk_no_early_ea: assert property (@(posedge clk) disable iff (!resetn)
		state_q == EAG_READ |-> !ea_valid_q)
		else $error("address presented during indirect reads");
endmodule : eag_top

/* test_effective_address_generator.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the effective address generator
// ----------------------------------------------------------------
module test_effective_address_generator;
	import eag_pkg::*;
	logic clk, resetn, start, mem_ack, xr_wr, bp_wr, bp_wdata;
	logic [1:0] op_kind, imm_op, level, xr_wr_level, bp_wr_level, extra_us_q;
	logic [15:0] instr, loc, acc_in, mem_rdata, xr_wdata, mem_addr_q, ea_q, acc_out_q;
	logic busy_q, mem_rd_q, ea_valid_q, acc_valid_q, bflag_q;
	logic [3:0] lat;
	int num_errors = 0;
	int cmp_count = 0;
	int reads_seen = 0;
	eag_top dut (.clk(clk), .resetn(resetn), .start(start), .op_kind(op_kind),
		.imm_op(imm_op), .instr(instr), .loc(loc), .level(level), .acc_in(acc_in),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .xr_wr(xr_wr),
		.xr_wr_level(xr_wr_level), .xr_wdata(xr_wdata), .bp_wr(bp_wr),
		.bp_wr_level(bp_wr_level), .bp_wdata(bp_wdata), .busy_q(busy_q),
		.mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .ea_q(ea_q), .ea_valid_q(ea_valid_q),
		.acc_out_q(acc_out_q), .acc_valid_q(acc_valid_q), .bflag_q(bflag_q),
		.extra_us_q(extra_us_q));
	eag_mem_model mem (.clk(clk), .resetn(resetn), .mem_rd_q(mem_rd_q),
		.mem_addr_q(mem_addr_q), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// ----------------------------------------------------------------
	// Clock, read counter and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Completed memory reads
	always @(posedge clk) begin
		if (mem_rd_q && mem_ack) reads_seen++;
	end
	initial begin
		#400000;
		num_errors++;
		close_out();
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Expected memory content, same law as the model
	function automatic logic [15:0] wd(input logic [15:0] a);
		return {a[7:0], a[15:8]} + 16'h0101;
	endfunction : wd
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Write an index register and a page flag of one level
	task automatic set_level(input logic [1:0] lv, input logic [15:0] xv, input logic bf);
		xr_wr = 1'b1;
		xr_wr_level = lv;
		xr_wdata = xv;
		bp_wr = 1'b1;
		bp_wr_level = lv;
		bp_wdata = bf;
		@(negedge clk);
		xr_wr = 1'b0;
		bp_wr = 1'b0;
		@(negedge clk);
	endtask : set_level
	// One address request, started at a falling edge
	task automatic run_ea(input logic [1:0] k, input logic [15:0] ins, input logic [15:0] lc,
		input logic [1:0] lv, input logic [15:0] ea, input int us, input int nr);
		int n;
		int lo;
		start = 1'b1;
		op_kind = k;
		instr = ins;
		loc = lc;
		level = lv;
		reads_seen = 0;
		@(negedge clk);
		start = 1'b0;
		n = 1;
		chk(16'(busy_q), 16'h0001);
		while (ea_valid_q !== 1'b1 && n < 600) begin
			@(negedge clk);
			n++;
		end
		lo = (us == 0) ? 2 : us * 125;
		chk(16'(ea_valid_q), 16'h0001);
		chk(16'(busy_q), 16'h0000);
		chk(ea_q, ea);
		chk({14'h0000, extra_us_q}, 16'(us));
		chk(16'(reads_seen), 16'(nr));
		chk(16'(n >= lo && n <= lo + 4 + nr * 6), 16'h0001);
	endtask : run_ea
	// One immediate byte request
	task automatic run_imm(input logic [1:0] op, input logic [15:0] ins, input logic [15:0] a,
		input logic [15:0] exp);
		start = 1'b1;
		op_kind = EAG_KIND_IMM;
		imm_op = op;
		instr = ins;
		acc_in = a;
		// Strobe stays up so the next immediate follows at once
		@(negedge clk);
		chk(16'(acc_valid_q), 16'h0001);
		chk(acc_out_q, exp);
	endtask : run_imm
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] ins, lc, xv, bp, a;
		logic [1:0] lv;
		logic bf;
		int nr;
		{start, op_kind, imm_op, instr, loc, level, acc_in} = '0;
		{xr_wr, xr_wr_level, xr_wdata, bp_wr, bp_wr_level, bp_wdata} = '0;
		lat = 4'h0;
		resetn = 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		// Level one wraps on indexing, level two uses the fixed base page
		set_level(2'h1, 16'hfff0, 1'b0);
		set_level(2'h2, 16'h0123, 1'b1);
		// All eight address modes on both levels, quick and slow memory
		for (int p = 0; p < 2; p++) begin
			for (int m = 0; m < 8; m++) begin
				lv = p ? 2'h2 : 2'h1;
				xv = p ? 16'h0123 : 16'hfff0;
				bf = p[0];
				lc = p ? 16'h0400 : 16'he234;
				lat = p ? 4'h3 : 4'h0;
				ins = {4'h2, 3'(m), 9'h1a5};
				bp = bf ? {7'h01, 9'h1a5} : {3'h0, {1'b0, lc[15:13]} + 4'h1, 9'h1a5};
				// Page step, then indirection, then index
				a = m[0] ? {lc[15:9], 9'h1a5} : wd(bp);
				nr = m[0] ? 0 : 1;
				if (m[2]) begin
					a = wd(a);
					nr++;
				end
				if (m[1]) a = a + xv;
				run_ea(EAG_KIND_MEMREF, ins, lc, lv, a, m[2] + m[1] + !m[0], nr);
				chk(16'(bflag_q), 16'(bf));
			end
		end
		// Index relative direct and indirect forms on both levels
		for (int p = 0; p < 2; p++) begin
			for (int k = 1; k < 3; k++) begin
				xv = p ? 16'h0123 : 16'hfff0;
				a = (k == 1) ? xv + 16'h000d : wd(xv) + 16'h000d;
				run_ea(2'(k), 16'h00fd, 16'h0400, p ? 2'h2 : 2'h1, a, 0, k - 1);
			end
		end
		// Immediate byte load, add and subtract back to back
		run_imm(EAG_IMM_LOAD, 16'h00fe, 16'h8005, 16'h00fe);
		run_imm(EAG_IMM_ADD, 16'h00fe, 16'h8005, 16'h8103);
		run_imm(EAG_IMM_SUB, 16'h00fe, 16'h8005, 16'h7f07);
		start = 1'b0;
		close_out();
	end
endmodule : test_effective_address_generator
